// ==== design/tip_dev.sv ====
// Tuner register port: two-wire slave with a 48-entry register array.
// Assumes link_clk oversamples scl and sda; register writes are reported on clk.
`timescale 1ns/100ps
`include "tip_map.svh"

// Overview of operation
// - Strap low: answer only C0h/C1h.
// - Strap high: answer only C2h/C3h.
// - Pointer byte follows; valid 00h to 2Fh.
// - Every byte travels MSB first.
// - Sample master data on rising clock.
// - Master keeps data stable while clock high.
// - Ack low from eighth to ninth fall.
// - Read bits change on fall, master samples rise.
// - Sample master acknowledge on rising clock.
// - Master alone makes the serial clock.
// - Write: address, pointer, one data, stop.
// - Extra write data bytes are discarded.
// - Read: pointer write, restart, read address, byte.
// - Master NACKs the read byte, then stops.
// - Start/stop are data edges while clock high.
module tip_dev (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          link_clk,
  input  wire logic          slave_address_strap,
  tip_if.device              bus,
  output logic               wr_stb,
  output tip_pkg::tip_regidx_t wr_addr,
  output tip_pkg::tip_byte_t wr_data
);
  import tip_pkg::*;

  // Link domain.
  logic        link_rst;
  logic        scl_s;
  logic        sda_s;
  logic        strap_s;
  logic        scl_q;
  logic        sda_q;
  logic        strap_lat;
  tip_dev_st_e st;
  logic [3:0]  cnt;
  tip_byte_t   sh;
  tip_byte_t   ptr;
  logic        rw;
  logic        first;
  logic        mack;
  tip_byte_t   regs [0:`TIP_REG_NUM-1];
  tip_regidx_t x_addr;
  tip_byte_t   x_data;
  logic        x_tog;

  // System domain.
  logic        tog_s;
  logic        tog_q;

  tip_sync u_rst   (.clk(link_clk), .d(sys_rst),             .q(link_rst));
  tip_sync u_scl   (.clk(link_clk), .d(bus.scl),             .q(scl_s));
  tip_sync u_sda   (.clk(link_clk), .d(bus.sda),             .q(sda_s));
  tip_sync u_strap (.clk(link_clk), .d(slave_address_strap), .q(strap_s));
  tip_sync u_tog   (.clk(clk),      .d(x_tog),               .q(tog_s));

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  wire tip_byte_t my_addr = strap_lat ? `TIP_ADDR_STRAP_HI : `TIP_ADDR_STRAP_LO;
  wire addr_hit = (sh[7:1] == my_addr[7:1]);
  wire ptr_ok   = (ptr <= `TIP_REG_LAST);
  wire tip_byte_t rd_byte = ptr_ok ? regs[ptr[5:0]] : `TIP_RD_EMPTY;
  wire rx_state = (st == TIP_D_ADDR) | (st == TIP_D_PTR) | (st == TIP_D_DATA);
  wire shift_in = rx_state & scl_rise & (cnt != `TIP_BITS_BYTE);
  wire byte_end = scl_fall & (cnt == `TIP_BITS_BYTE);
  // Only the first data byte of a transfer lands in the array.
  wire mem_we   = (st == TIP_D_DATA) & byte_end & first & ptr_ok;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      strap_lat <= strap_s;
    end else begin
      scl_q     <= scl_s;
      sda_q     <= sda_s;
    end
  end

  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      regs[ptr[5:0]] <= sh;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      x_addr <= '0;
      x_data <= '0;
      x_tog  <= 1'b0;
    end else if (mem_we) begin
      x_addr <= ptr[5:0];
      x_data <= sh;
      x_tog  <= ~x_tog;
    end
  end

  // The serial clock is only observed, never driven, by this end.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      st           <= TIP_D_IDLE;
      cnt          <= '0;
      sh           <= '0;
      ptr          <= '0;
      rw           <= 1'b0;
      first        <= 1'b0;
      mack         <= 1'b0;
      bus.sda_s_o  <= 1'b0;
      bus.sda_s_oe <= 1'b0;
    end else if (start_c) begin
      // A repeated start restarts address decoding without losing the pointer.
      st           <= TIP_D_ADDR;
      cnt          <= '0;
      bus.sda_s_oe <= 1'b0;
    end else if (stop_c) begin
      st           <= TIP_D_IDLE;
      bus.sda_s_oe <= 1'b0;
    end else begin
      if (shift_in) begin
        sh  <= {sh[6:0], sda_s};
        cnt <= cnt + 4'h1;
      end
      case (st)
        TIP_D_IDLE: begin
          bus.sda_s_oe <= 1'b0;
        end
        TIP_D_ADDR: begin
          if (byte_end) begin
            if (addr_hit) begin
              bus.sda_s_oe <= 1'b1;
              rw           <= sh[0];
              st           <= TIP_D_ADDR_ACK;
            end else begin
              st <= TIP_D_IDLE;
            end
          end
        end
        TIP_D_ADDR_ACK: begin
          if (scl_fall) begin
            cnt <= '0;
            if (rw) begin
              bus.sda_s_oe <= ~rd_byte[`TIP_IDX_MSB];
              sh           <= {rd_byte[6:0], 1'b0};
              st           <= TIP_D_RD;
            end else begin
              bus.sda_s_oe <= 1'b0;
              st           <= TIP_D_PTR;
            end
          end
        end
        TIP_D_PTR: begin
          if (byte_end) begin
            bus.sda_s_oe <= 1'b1;
            ptr          <= sh;
            st           <= TIP_D_PTR_ACK;
          end
        end
        TIP_D_PTR_ACK: begin
          if (scl_fall) begin
            bus.sda_s_oe <= 1'b0;
            cnt          <= '0;
            first        <= 1'b1;
            st           <= TIP_D_DATA;
          end
        end
        TIP_D_DATA: begin
          if (byte_end) begin
            bus.sda_s_oe <= 1'b1;
            first        <= 1'b0;
            st           <= TIP_D_DATA_ACK;
          end
        end
        TIP_D_DATA_ACK: begin
          if (scl_fall) begin
            bus.sda_s_oe <= 1'b0;
            cnt          <= '0;
            st           <= TIP_D_DATA;
          end
        end
        TIP_D_RD: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end
          if (scl_fall) begin
            if (cnt == `TIP_BITS_BYTE) begin
              bus.sda_s_oe <= 1'b0;
              st           <= TIP_D_RD_ACK;
            end else begin
              bus.sda_s_oe <= ~sh[`TIP_IDX_MSB];
              sh           <= {sh[6:0], 1'b0};
            end
          end
        end
        TIP_D_RD_ACK: begin
          if (scl_rise) begin
            mack <= ~sda_s;
          end
          if (scl_fall) begin
            cnt <= '0;
            // A master ACK asks for the same register again; NACK ends the read.
            if (mack) begin
              bus.sda_s_oe <= ~rd_byte[`TIP_IDX_MSB];
              sh           <= {rd_byte[6:0], 1'b0};
              st           <= TIP_D_RD;
            end else begin
              st <= TIP_D_IDLE;
            end
          end
        end
        default: begin
          st           <= TIP_D_IDLE;
          bus.sda_s_oe <= 1'b0;
        end
      endcase
    end
  end

  // The address and data are held since the toggle moved, so they are stable
  // by the time the toggle has crossed two flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tog_q   <= 1'b0;
      wr_stb  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      tog_q  <= tog_s;
      wr_stb <= tog_s ^ tog_q;
      if (tog_s ^ tog_q) begin
        wr_addr <= x_addr;
        wr_data <= x_data;
      end
    end
  end
endmodule // tip_dev

// ==== design/tip_map.svh ====
// Constants of the two-wire tuner register port: addresses, limits and timing.
// Assumes inclusion by bare name from every design file that needs a figure.
`ifndef TIP_MAP_SVH
`define TIP_MAP_SVH

// Slave address bytes, write form, for each strap level.
`define TIP_ADDR_STRAP_LO   8'hC0
`define TIP_ADDR_STRAP_HI   8'hC2
`define TIP_ADDR_RD_BIT     8'h01

// Highest valid register pointer and the size of the register array.
`define TIP_REG_LAST        8'h2F
`define TIP_REG_NUM         48
`define TIP_RD_EMPTY        8'h00

// Bit counts of one byte slot on the link.
`define TIP_BITS_BYTE       4'h8
`define TIP_BITS_ACK        4'h9
`define TIP_IDX_MSB         3'h7

// Serial clock made by the master from clk.
`define TIP_CLK_PERIOD_NS   5
`define TIP_SCL_PERIOD_NS   200
`define TIP_QTR_CYC         (`TIP_SCL_PERIOD_NS / (4 * `TIP_CLK_PERIOD_NS))

`endif

// ==== design/tip_pkg.sv ====
// Types shared by both ends of the two-wire tuner register port.
// Assumes tip_map.svh supplies every numeric constant.
package tip_pkg;

  typedef logic [7:0] tip_byte_t;
  typedef logic [5:0] tip_regidx_t;

  typedef enum logic [3:0] {
    TIP_D_IDLE,
    TIP_D_ADDR,
    TIP_D_ADDR_ACK,
    TIP_D_PTR,
    TIP_D_PTR_ACK,
    TIP_D_DATA,
    TIP_D_DATA_ACK,
    TIP_D_RD,
    TIP_D_RD_ACK
  } tip_dev_st_e;

  typedef enum logic [2:0] {
    TIP_M_IDLE,
    TIP_M_START,
    TIP_M_BYTE,
    TIP_M_RESTART,
    TIP_M_STOP
  } tip_mst_st_e;

endpackage

// ==== design/tip_if.sv ====
// Two-wire link between the master and the tuner register port.
// Assumes both ends only pull the data line low; the wire level is resolved here.
`timescale 1ns/100ps
interface tip_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;

  // Open drain: the line is low while any enabled driver pulls low.
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (
    output scl,
    output sda_m_o,
    output sda_m_oe,
    input  sda
  );

  modport device (
    input  scl,
    input  sda,
    output sda_s_o,
    output sda_s_oe
  );
endinterface

// ==== design/tip_sync.sv ====
// Two-flop synchroniser for one level entering a clock domain.
// Assumes the input is a level held much longer than two destination clocks.
`timescale 1ns/100ps
module tip_sync (
  input  wire logic clk,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule // tip_sync

// ==== design/tip_mst.sv ====
// Master end of the tuner register port: single-byte register writes and reads.
// Assumes clk runs at 200 MHz; the serial clock is divided from it and driven out.
`timescale 1ns/100ps
`include "tip_map.svh"
module tip_mst (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  tip_if.master              bus,
  input  wire logic          req,
  input  wire logic          rd,
  input  wire logic          strap_hi,
  input  tip_pkg::tip_byte_t ptr,
  input  tip_pkg::tip_byte_t wdata,
  output logic               busy,
  output logic               done,
  output logic               nack,
  output tip_pkg::tip_byte_t rdata
);
  import tip_pkg::*;

  logic        sda_s;
  tip_mst_st_e st;
  logic [7:0]  qcnt;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic [1:0]  bytn;
  tip_byte_t   sh;
  tip_byte_t   dev_l;
  tip_byte_t   ptr_l;
  tip_byte_t   wd_l;
  logic        rd_l;
  logic        got_nack;

  tip_sync u_sda (.clk(clk), .d(bus.sda), .q(sda_s));

  wire tick    = (qcnt == 8'(`TIP_QTR_CYC - 1));
  wire rx_byte = rd_l & (bytn == 2'd3);
  wire tip_byte_t cur_byte = (bytn == 2'd0) ? dev_l :
                             (bytn == 2'd1) ? ptr_l :
                             (bytn == 2'd2) ? (rd_l ? (dev_l | `TIP_ADDR_RD_BIT) : wd_l) :
                             8'hFF;
  wire tx_bit  = cur_byte[`TIP_IDX_MSB - bitn[2:0]];
  wire data_bit = (bitn != `TIP_BITS_BYTE);

  always_ff @(posedge clk) begin
    if (sys_rst || st == TIP_M_IDLE || tick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st           <= TIP_M_IDLE;
      q            <= '0;
      bitn         <= '0;
      bytn         <= '0;
      sh           <= '0;
      dev_l        <= '0;
      ptr_l        <= '0;
      wd_l         <= '0;
      rd_l         <= 1'b0;
      got_nack     <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      nack         <= 1'b0;
      rdata        <= '0;
      bus.scl      <= 1'b1;
      bus.sda_m_o  <= 1'b0;
      bus.sda_m_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (st != TIP_M_IDLE && tick) begin
        q <= q + 2'd1;
      end
      case (st)
        TIP_M_IDLE: begin
          if (req) begin
            dev_l    <= strap_hi ? `TIP_ADDR_STRAP_HI : `TIP_ADDR_STRAP_LO;
            ptr_l    <= ptr;
            wd_l     <= wdata;
            rd_l     <= rd;
            bytn     <= '0;
            bitn     <= '0;
            q        <= '0;
            got_nack <= 1'b0;
            busy     <= 1'b1;
            st       <= TIP_M_START;
          end
        end
        TIP_M_START: begin
          if (tick) begin
            case (q)
              2'd0: bus.sda_m_oe <= 1'b0;
              2'd1: bus.sda_m_oe <= 1'b1;
              2'd2: bus.scl      <= 1'b0;
              default: st        <= TIP_M_BYTE;
            endcase
          end
        end
        TIP_M_BYTE: begin
          if (tick) begin
            case (q)
              // Ack slots are released: the device acks, and the read byte gets NACK.
              2'd0: bus.sda_m_oe <= data_bit ? ~tx_bit : 1'b0;
              2'd1: bus.scl      <= 1'b1;
              2'd2: begin
                if (data_bit) begin
                  sh <= {sh[6:0], sda_s};
                end else if (!rx_byte && sda_s) begin
                  got_nack <= 1'b1;
                end
              end
              default: begin
                bus.scl <= 1'b0;
                if (data_bit) begin
                  bitn <= bitn + 4'h1;
                end else begin
                  bitn <= '0;
                  if (got_nack) begin
                    st <= TIP_M_STOP;
                  end else if (rx_byte) begin
                    rdata <= sh;
                    st    <= TIP_M_STOP;
                  end else if (rd_l && bytn == 2'd1) begin
                    bytn <= 2'd2;
                    st   <= TIP_M_RESTART;
                  end else if (!rd_l && bytn == 2'd2) begin
                    st <= TIP_M_STOP;
                  end else begin
                    bytn <= bytn + 2'd1;
                  end
                end
              end
            endcase
          end
        end
        TIP_M_RESTART: begin
          if (tick) begin
            case (q)
              2'd0: bus.sda_m_oe <= 1'b0;
              2'd1: bus.scl      <= 1'b1;
              2'd2: bus.sda_m_oe <= 1'b1;
              default: begin
                bus.scl <= 1'b0;
                st      <= TIP_M_BYTE;
              end
            endcase
          end
        end
        TIP_M_STOP: begin
          if (tick) begin
            case (q)
              2'd0: bus.sda_m_oe <= 1'b1;
              2'd1: bus.scl      <= 1'b1;
              2'd2: bus.sda_m_oe <= 1'b0;
              default: begin
                busy <= 1'b0;
                done <= 1'b1;
                nack <= got_nack;
                st   <= TIP_M_IDLE;
              end
            endcase
          end
        end
        default: st <= TIP_M_IDLE;
      endcase
    end
  end
endmodule // tip_mst

// ==== test/tip_properties.sv ====
// Link-level assertions for the two-wire register port, watching the shared interface.
// Assumes scl comes from a clk flop, so sampling on clk sees every scl phase.
`timescale 1ns/100ps
module tip_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slave_address_strap,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  logic       scl_q;
  logic       sda_q;
  logic       rdp;
  logic       ok;
  logic [3:0] cnt;
  logic [2:0] nb;
  logic [7:0] sh;
  wire rise = scl & ~scl_q;
  wire strt = scl & scl_q & sda_q & ~sda;
  wire stp  = scl & scl_q & ~sda_q & sda;
  wire hit  = sh[7:1] == {6'h30, slave_address_strap};
  wire ack9 = rise & (cnt == 4'h8);
  // Slot 1 of a byte follows either a start (count 0) or a finished byte (count 9).
  wire wbit = rise & (cnt != 4'h8) & ~(rdp & ok & ((nb != 3'h0) | (cnt == 4'h9)));

  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // Counts restart at every start, so a repeated start decodes the address again.
  always_ff @(posedge clk) begin
    if (sys_rst | strt) begin
      cnt <= 4'h0;
      nb  <= 3'h0;
      rdp <= 1'b0;
      ok  <= 1'b0;
    end else if (rise) begin
      sh  <= {sh[6:0], sda};
      cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      nb  <= nb + {2'h0, cnt == 4'h9};
      if ((cnt == 4'h7) && (nb == 3'h0)) rdp <= sda;
      if (ack9 && (nb == 3'h0)) ok <= hit;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_addr_match: assert property (ack9 && nb == 3'h0 |-> sda_s_oe == hit)
    else $error("address acknowledge does not follow the strap pair");
  a_byte_ack: assert property (ack9 && nb != 3'h0 && ok && !rdp |-> sda_s_oe)
    else $error("written byte not acknowledged");
  a_master_bits: assert property (wbit |-> !sda_s_oe)
    else $error("device drives the line during a master bit");
  a_ack_hold: assert property (ack9 && sda_s_oe |=> sda_s_oe [*8])
    else $error("acknowledge dropped while scl high");
  a_ack_release: assert property ($fell(scl) && cnt == 4'h9 && !rdp |-> ##[1:16] !sda_s_oe)
    else $error("acknowledge not released after ninth fall");
  a_read_edge: assert property ($changed(sda_s_oe) |-> !scl && !scl_q)
    else $error("device data changed while scl high");
  a_read_nack: assert property (ack9 && nb != 3'h0 && rdp && ok |-> !sda_s_oe && !sda_m_oe)
    else $error("read byte slot nine not left to a master nack");
  // The count has already moved on by the time a stop or a repeated start is made, so the
  // only legal change of the master's line while scl is high is one that forms a condition.
  a_master_stable: assert property ($changed(sda_m_oe) && scl && scl_q |->
    strt || stp)
    else $error("master data changed while scl high inside a byte");
  a_scl_high: assert property ($rose(scl) |=> scl [*8])
    else $error("scl high phase too short");
  a_start_low: assert property ($rose(sda_m_oe) && scl |-> ##[1:12] !scl)
    else $error("scl not lowered after start");
endmodule // tip_properties

// ==== test/tb_tuner_i2c_register_port.sv ====
// Self-checking bench joining master and device ends over the two-wire interface.
// Assumes a 200 MHz clk and an unrelated 12 ns link_clk; the strap is latched in reset.
`timescale 1ns/100ps
module tb_tuner_i2c_register_port;
  import tip_pkg::*;
  logic        clk, link_clk, sys_rst, strap, req, rd, strap_hi;
  logic        busy, done, nack, wr_stb;
  tip_byte_t   ptr, wdata, rdata, wr_data;
  tip_regidx_t wr_addr;
  int          bad_count, samples_checked, cyc, stb_n;

  tip_if u_tip_if ();
  tip_dev u_tip_dev (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .slave_address_strap(strap), .bus(u_tip_if), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data));
  tip_mst u_tip_mst (.clk(clk), .sys_rst(sys_rst), .bus(u_tip_if), .req(req), .rd(rd),
    .strap_hi(strap_hi), .ptr(ptr), .wdata(wdata), .busy(busy), .done(done), .nack(nack),
    .rdata(rdata));
  tip_properties u_tip_properties (.clk(clk), .sys_rst(sys_rst), .slave_address_strap(strap),
    .scl(u_tip_if.scl), .sda(u_tip_if.sda), .sda_m_oe(u_tip_if.sda_m_oe),
    .sda_s_oe(u_tip_if.sda_s_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The odd offset keeps the link clock out of phase with clk.
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (wr_stb === 1'b1) stb_n++;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    strap   <= s;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // One transfer; the next may start at the edge after done.
  task automatic xfer(input logic r, input logic s, input tip_byte_t p, input tip_byte_t d);
    int n;
    n = 0;
    @(posedge clk);
    req      <= 1'b1;
    rd       <= r;
    strap_hi <= s;
    ptr      <= p;
    wdata    <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    check({7'h00, busy}, 8'h01, "busy after request");
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h00, done}, 8'h01, "transfer completion");
    check({7'h00, busy}, 8'h00, "busy after completion");
  endtask

  // Data differs per strap pass, so the second pass cannot be satisfied by the first one's
  // leftovers in the array, which is not cleared by reset.
  task automatic t_write_read(input logic s);
    int        b;
    tip_byte_t d_top;
    tip_byte_t d_bot;
    b     = stb_n;
    d_top = s ? 8'h69 : 8'h96;
    d_bot = s ? 8'hB4 : 8'h4B;
    xfer(1'b0, s, 8'h2F, d_top);
    check(8'(stb_n - b), 8'h01, "write strobes");
    check({2'h0, wr_addr}, 8'h2F, "top index");
    check(wr_data, d_top, "write data");
    check({7'h00, nack}, 8'h00, "write acknowledged");
    xfer(1'b0, s, 8'h00, d_bot);
    check({2'h0, wr_addr}, 8'h00, "bottom index");
    check(wr_data, d_bot, "second write data");
    check({7'h00, nack}, 8'h00, "second write acknowledged");
    xfer(1'b1, s, 8'h2F, 8'h00);
    check(rdata, d_top, "read top");
    check({7'h00, nack}, 8'h00, "read acknowledged");
    xfer(1'b1, s, 8'h00, 8'h00);
    check(rdata, d_bot, "read bottom");
    $display("write and read test done, strap %b", s);
  endtask

  task automatic t_foreign(input logic s);
    int b;
    b = stb_n;
    xfer(1'b0, ~s, 8'h05, 8'h77);
    check({7'h00, nack}, 8'h01, "foreign write nack");
    check(8'(stb_n - b), 8'h00, "foreign write strobes");
    xfer(1'b1, ~s, 8'h2F, 8'h00);
    check({7'h00, nack}, 8'h01, "foreign read nack");
    $display("foreign address test done, strap %b", s);
  endtask

  task automatic t_bad_ptr(input logic s);
    int b;
    b = stb_n;
    xfer(1'b0, s, 8'h30, 8'h11);
    check({7'h00, nack}, 8'h00, "pointer past end acked");
    check(8'(stb_n - b), 8'h00, "pointer past end strobes");
    xfer(1'b1, s, 8'h30, 8'h00);
    check(rdata, 8'h00, "pointer past end read");
    $display("invalid pointer test done, strap %b", s);
  endtask

  initial begin
    sys_rst         = 1'b1;
    strap           = 1'b0;
    req             = 1'b0;
    rd              = 1'b0;
    strap_hi        = 1'b0;
    ptr             = 8'h00;
    wdata           = 8'h00;
    bad_count       = 0;
    samples_checked = 0;
    cyc             = 0;
    stb_n           = 0;
    // The second pass resets in mid-run and swaps the strap level.
    for (int i = 0; i < 2; i++) begin
      do_reset(i[0]);
      t_write_read(i[0]);
      t_foreign(i[0]);
      t_bad_ptr(i[0]);
    end
    complete_run();
  end
endmodule // tb_tuner_i2c_register_port
